// file: hdl/cmpms_edge.sv
// synchroniser and edge detector for the asynchronous comparator output
module cmpms_edge #(
    parameter int SYNC_STAGES = cmpms_pkg::CMPMS_SYNC_STAGES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic raw_level,    // comparator output, asynchronous to clk_sys
    input wire logic enable,       // comparator powered
    output logic level_q,          // synchronised, forced low while disabled
    output logic rise_q,           // one-cycle pulse on rising transition
    output logic fall_q            // one-cycle pulse on falling transition
);
    import cmpms_pkg::*;

    // refuse a chain too short to settle metastability
    if (SYNC_STAGES < 2) begin : g_bad_depth
        $error("cmpms_edge: SYNC_STAGES must be at least 2");
    end

    logic [SYNC_STAGES-1:0] sync_q;  // first stage feeds only the second
    logic level_d;

    // synchroniser chain
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[SYNC_STAGES-2:0], raw_level};
        end
    end

    // a disabled comparator reads low; last stage only
    assign level_d = enable & sync_q[SYNC_STAGES-1];

    // level register and edge pulses
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            level_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            level_q <= level_d;
            rise_q <= level_d & ~level_q;
            fall_q <= ~level_d & level_q;
        end
    end

endmodule : cmpms_edge

// file: hdl/cmpms_pkg.sv
// constants for the comparator mode and input select register bank
package cmpms_pkg;

    // special-function-register addresses
    localparam logic [7:0] CMPMS_ADDR_CONTROL = 8'h9B;  // enable, flags, hysteresis
    localparam logic [7:0] CMPMS_ADDR_MODE = 8'h9D;     // comparator_mode_irq_enable
    localparam logic [7:0] CMPMS_ADDR_INSEL = 8'h9F;    // comparator_input_select

    // reset values
    localparam logic [7:0] CMPMS_CONTROL_RST = 8'h00;
    localparam logic [7:0] CMPMS_MODE_RST = 8'h02;
    localparam logic [7:0] CMPMS_INSEL_RST = 8'hFF;

    // control register fields
    localparam int CMPMS_CTL_EN_BIT = 7;
    localparam int CMPMS_CTL_OUT_BIT = 6;
    localparam int CMPMS_CTL_RISE_BIT = 5;
    localparam int CMPMS_CTL_FALL_BIT = 4;
    localparam int CMPMS_CTL_HYP_LSB = 2;
    localparam int CMPMS_CTL_HYN_LSB = 0;

    // mode register fields
    localparam int CMPMS_MODE_RIE_BIT = 5;
    localparam int CMPMS_MODE_FIE_BIT = 4;
    localparam int CMPMS_MODE_MD_LSB = 0;
    localparam logic [7:0] CMPMS_MODE_WMASK = 8'h33;  // bits 7:6 and 3:2 read zero

    // input select fields
    localparam int CMPMS_INSEL_NEG_LSB = 4;
    localparam int CMPMS_INSEL_POS_LSB = 0;

    // select codes
    localparam logic [3:0] CMPMS_CODE_RSVD_LO = 4'h6;  // first code absent on small package
    localparam logic [3:0] CMPMS_CODE_REG = 4'h8;      // regulator output
    localparam int CMPMS_PIN_COUNT = 8;                // port pins per comparator input

    // synchroniser depth for the raw comparator output
    localparam int CMPMS_SYNC_STAGES = 2;

endpackage : cmpms_pkg

// file: hdl/cmpms_top.sv
// comparator mode, interrupt enable and input select register bank
//
// Contract
// - mode bits 7:6, 3:2 read zero, writes ignored
// - mode bit 5 enables rising-edge interrupt
// - mode bit 4 enables falling-edge interrupt
// - mode bits 1:0 select response/power mode
// - select bits 7:4 choose negative input
// - select bits 3:0 choose positive input
// - small package: codes 0110, 0111 reserved
// - edges set sticky flags until software clears
// - comparator powered only when enabled; output low otherwise
module cmpms_top #(
    parameter bit SMALL_PACKAGE = 1'b0  // fewer port pins behind the multiplexer
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic cmp_raw,
    output logic comparator_enable,
    output logic [1:0] response_mode,
    output logic [1:0] hyst_pos,
    output logic [1:0] hyst_neg,
    output logic [cmpms_pkg::CMPMS_PIN_COUNT-1:0] positive_pin_sel,
    output logic positive_regulator_sel,
    output logic [cmpms_pkg::CMPMS_PIN_COUNT-1:0] negative_pin_sel,
    output logic negative_regulator_sel,
    output logic cmp_out_routed,
    output logic cmp_irq
);
    import cmpms_pkg::*;

    // the pin vector must hold every port-pin code below the regulator code
    if (CMPMS_PIN_COUNT != int'(CMPMS_CODE_REG)) begin : g_bad_pins
        $error("cmpms_top: pin count must match the regulator code");
    end

    // one-hot pin select from a four-bit code; reserved and unused codes give none
    function automatic logic [CMPMS_PIN_COUNT-1:0] pin_decode(input logic [3:0] code,
                                                             input logic small_pkg);
        logic [CMPMS_PIN_COUNT-1:0] sel;
        sel = '0;
        if (code < CMPMS_CODE_REG) begin
            // nothing bonded behind the top two codes on the small package
            if (!(small_pkg && code >= CMPMS_CODE_RSVD_LO)) begin
                sel[code[2:0]] = 1'b1;
            end
        end
        return sel;
    endfunction : pin_decode

    // write strobes per register
    logic wr_control;
    logic wr_mode;
    logic wr_insel;

    assign wr_control = sfr_wr && (sfr_addr == CMPMS_ADDR_CONTROL);
    assign wr_mode = sfr_wr && (sfr_addr == CMPMS_ADDR_MODE);
    assign wr_insel = sfr_wr && (sfr_addr == CMPMS_ADDR_INSEL);

    // stored register bits
    logic enable_q;             // comparator power
    logic [1:0] hyp_q;          // positive hysteresis
    logic [1:0] hyn_q;          // negative hysteresis
    logic rise_event_flag_q;    // sticky rising edge
    logic fall_event_flag_q;    // sticky falling edge
    logic rise_irq_enable_q;
    logic fall_irq_enable_q;
    logic [1:0] response_mode_q;
    logic [3:0] negative_input_code_q;
    logic [3:0] positive_input_code_q;

    // synchronised comparator level and edge pulses
    logic level_sync;
    logic rise_pulse;
    logic fall_pulse;

    cmpms_edge #(
        .SYNC_STAGES(CMPMS_SYNC_STAGES)
    ) u_edge (
        .clk_sys(clk_sys),
        .rst(rst),
        .raw_level(cmp_raw),
        .enable(enable_q),
        .level_q(level_sync),
        .rise_q(rise_pulse),
        .fall_q(fall_pulse)
    );

    // control register: enable and hysteresis
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable_q <= CMPMS_CONTROL_RST[CMPMS_CTL_EN_BIT];
            hyp_q <= CMPMS_CONTROL_RST[CMPMS_CTL_HYP_LSB +: 2];
            hyn_q <= CMPMS_CONTROL_RST[CMPMS_CTL_HYN_LSB +: 2];
        end else if (wr_control) begin
            enable_q <= sfr_wdata[CMPMS_CTL_EN_BIT];
            hyp_q <= sfr_wdata[CMPMS_CTL_HYP_LSB +: 2];
            hyn_q <= sfr_wdata[CMPMS_CTL_HYN_LSB +: 2];
        end
    end

    // sticky edge flags; an edge in the clearing cycle still sets the flag
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rise_event_flag_q <= CMPMS_CONTROL_RST[CMPMS_CTL_RISE_BIT];
            fall_event_flag_q <= CMPMS_CONTROL_RST[CMPMS_CTL_FALL_BIT];
        end else begin
            if (rise_pulse) begin
                rise_event_flag_q <= 1'b1;
            end else if (wr_control) begin
                // software may also write one, which sets the flag by hand
                rise_event_flag_q <= sfr_wdata[CMPMS_CTL_RISE_BIT];
            end
            if (fall_pulse) begin
                fall_event_flag_q <= 1'b1;
            end else if (wr_control) begin
                fall_event_flag_q <= sfr_wdata[CMPMS_CTL_FALL_BIT];
            end
        end
    end

    // mode register; unused bits are not stored at all
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rise_irq_enable_q <= CMPMS_MODE_RST[CMPMS_MODE_RIE_BIT];
            fall_irq_enable_q <= CMPMS_MODE_RST[CMPMS_MODE_FIE_BIT];
            response_mode_q <= CMPMS_MODE_RST[CMPMS_MODE_MD_LSB +: 2];
        end else if (wr_mode) begin
            rise_irq_enable_q <= sfr_wdata[CMPMS_MODE_RIE_BIT];
            fall_irq_enable_q <= sfr_wdata[CMPMS_MODE_FIE_BIT];
            response_mode_q <= sfr_wdata[CMPMS_MODE_MD_LSB +: 2];
        end
    end

    // input select register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            negative_input_code_q <= CMPMS_INSEL_RST[CMPMS_INSEL_NEG_LSB +: 4];
            positive_input_code_q <= CMPMS_INSEL_RST[CMPMS_INSEL_POS_LSB +: 4];
        end else if (wr_insel) begin
            negative_input_code_q <= sfr_wdata[CMPMS_INSEL_NEG_LSB +: 4];
            positive_input_code_q <= sfr_wdata[CMPMS_INSEL_POS_LSB +: 4];
        end
    end

    // read-back images of each register
    logic [7:0] control_image;
    logic [7:0] mode_image;
    logic [7:0] insel_image;
    logic [7:0] rdata_d;

    always_comb begin
        control_image = 8'h00;
        control_image[CMPMS_CTL_EN_BIT] = enable_q;
        control_image[CMPMS_CTL_OUT_BIT] = level_sync;
        control_image[CMPMS_CTL_RISE_BIT] = rise_event_flag_q;
        control_image[CMPMS_CTL_FALL_BIT] = fall_event_flag_q;
        control_image[CMPMS_CTL_HYP_LSB +: 2] = hyp_q;
        control_image[CMPMS_CTL_HYN_LSB +: 2] = hyn_q;
    end

    // unused mode bits are left at zero by the mask
    always_comb begin
        mode_image = 8'h00;
        mode_image[CMPMS_MODE_RIE_BIT] = rise_irq_enable_q;
        mode_image[CMPMS_MODE_FIE_BIT] = fall_irq_enable_q;
        mode_image[CMPMS_MODE_MD_LSB +: 2] = response_mode_q;
        mode_image = mode_image & CMPMS_MODE_WMASK;
    end

    always_comb begin
        insel_image = 8'h00;
        insel_image[CMPMS_INSEL_NEG_LSB +: 4] = negative_input_code_q;
        insel_image[CMPMS_INSEL_POS_LSB +: 4] = positive_input_code_q;
    end

    // address decode for reads; other addresses answer zero
    always_comb begin
        case (sfr_addr)
            CMPMS_ADDR_CONTROL: begin
                rdata_d = control_image;
            end
            CMPMS_ADDR_MODE: begin
                rdata_d = mode_image;
            end
            CMPMS_ADDR_INSEL: begin
                rdata_d = insel_image;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // read data registered; holds last value between reads
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= rdata_d;
        end
    end

    // analog-side controls, registered so outputs come straight from flops
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            comparator_enable <= 1'b0;
            response_mode <= CMPMS_MODE_RST[CMPMS_MODE_MD_LSB +: 2];
            hyst_pos <= CMPMS_CONTROL_RST[CMPMS_CTL_HYP_LSB +: 2];
            hyst_neg <= CMPMS_CONTROL_RST[CMPMS_CTL_HYN_LSB +: 2];
        end else begin
            comparator_enable <= enable_q;
            response_mode <= response_mode_q;
            hyst_pos <= hyp_q;
            hyst_neg <= hyn_q;
        end
    end

    // multiplexer steering; one cycle behind the select register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            positive_pin_sel <= '0;
            negative_pin_sel <= '0;
            positive_regulator_sel <= 1'b0;
            negative_regulator_sel <= 1'b0;
        end else begin
            positive_pin_sel <= pin_decode(positive_input_code_q, SMALL_PACKAGE);
            negative_pin_sel <= pin_decode(negative_input_code_q, SMALL_PACKAGE);
            positive_regulator_sel <= (positive_input_code_q == CMPMS_CODE_REG);
            negative_regulator_sel <= (negative_input_code_q == CMPMS_CODE_REG);
        end
    end

    // routed output and interrupt request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmp_out_routed <= 1'b0;
            cmp_irq <= 1'b0;
        end else begin
            // the sync level is forced low only a cycle after enable drops
            cmp_out_routed <= level_sync & enable_q;
            cmp_irq <= (rise_event_flag_q & rise_irq_enable_q)
                     | (fall_event_flag_q & fall_irq_enable_q);
        end
    end

    // chosen pins must be analog and crossbar-skipped by software; not checked here

endmodule : cmpms_top

// file: verification/cmpms_assertions.sv
// concurrent checks on the comparator mode and input select ports
module cmpms_assertions #(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic comparator_enable,
    input wire logic [1:0] response_mode,
    input wire logic [cmpms_pkg::CMPMS_PIN_COUNT-1:0] positive_pin_sel,
    input wire logic negative_regulator_sel,
    input wire logic cmp_out_routed,
    input wire logic cmp_irq
);
    import cmpms_pkg::*;
    // write strobes per register
    wire logic mode_wr = sfr_wr && sfr_addr == CMPMS_ADDR_MODE;
    wire logic insel_wr = sfr_wr && sfr_addr == CMPMS_ADDR_INSEL;
    wire logic ctl_wr = sfr_wr && sfr_addr == CMPMS_ADDR_CONTROL;
    // one-hot pin for a select code, none above seven, nor for six and seven on the small package
    function automatic logic [7:0] exp_pin(input logic [3:0] c);
        if (c[3] || (SMALL_PACKAGE && c[2:1] == 2'b11)) return 8'h00;
        return 8'h01 << c[2:0];
    endfunction : exp_pin
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_mode_rd; sfr_rd && sfr_addr == CMPMS_ADDR_MODE |=> (sfr_rdata & 8'hCC) == 8'h00; endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode spare bits");
    property p_mode_back; mode_wr ##2 sfr_rd && sfr_addr == CMPMS_ADDR_MODE
        |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'h33); endproperty
    a_mode_back: assert property (p_mode_back) else $error("mode readback");
    property p_resp; mode_wr |=> ##1 response_mode == $past(sfr_wdata[1:0], 2); endproperty
    a_resp: assert property (p_resp) else $error("response mode");
    property p_pos; insel_wr |=> ##1 positive_pin_sel == exp_pin($past(sfr_wdata[3:0], 2)); endproperty
    a_pos: assert property (p_pos) else $error("positive pin");
    property p_neg; insel_wr |=> ##1 negative_regulator_sel == ($past(sfr_wdata[7:4], 2) == 4'h8);
    endproperty
    a_neg: assert property (p_neg) else $error("negative regulator");
    property p_en; ctl_wr |=> ##1 comparator_enable == $past(sfr_wdata[7], 2); endproperty
    a_en: assert property (p_en) else $error("enable");
    property p_off; !comparator_enable [*2] |=> !cmp_out_routed; endproperty
    a_off: assert property (p_off) else $error("output while off");
    // the request lags its flags by a cycle, so a write one cycle back may still drop it
    property p_hold; cmp_irq && !sfr_wr && !$past(sfr_wr) |=> cmp_irq; endproperty
    a_hold: assert property (p_hold) else $error("irq dropped");
    property p_mask; mode_wr && sfr_wdata[5:4] == 2'b00 |=> ##1 !cmp_irq; endproperty
    a_mask: assert property (p_mask) else $error("masked irq");
    c_irq: cover property (cmp_irq);
    c_reg: cover property (insel_wr && sfr_wdata[3:0] == 4'h8);
    c_off: cover property (ctl_wr && !sfr_wdata[7]);
endmodule : cmpms_assertions

bind cmpms_top cmpms_assertions #(.SMALL_PACKAGE(SMALL_PACKAGE)) chk_i (
    .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .comparator_enable(comparator_enable),
    .response_mode(response_mode), .positive_pin_sel(positive_pin_sel),
    .negative_regulator_sel(negative_regulator_sel), .cmp_out_routed(cmp_out_routed),
    .cmp_irq(cmp_irq));

// file: verification/cmpms_cmp_model.sv
// behavioural analog comparator settling to a commanded level
module cmpms_cmp_model (
    input wire logic clk_sys,
    input wire logic power,
    input wire logic [1:0] response_mode,
    input wire logic want,
    output logic cmp_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hist_q = 4'h0; // slower modes look further back
    logic idle_q = 1'b0; // unpowered line wanders every cycle
    // history and wander advance every rising edge
    always @(posedge clk_sys) begin
        hist_q <= {hist_q[2:0], want};
        idle_q <= ~idle_q;
    end
    // no meaningful level unless powered
    assign cmp_raw = power ? hist_q[response_mode] : idle_q;
endmodule : cmpms_cmp_model

// file: verification/cmpms_top_tb.sv
// self-checking bench for the comparator mode and input select bank
module cmpms_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cmpms_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic want = 1'b0; // level the comparator heads for
    logic cmp_raw, cmp_en, cmp_irq, routed, pos_reg, neg_reg;
    logic [7:0] sfr_rdata, pos_sel, neg_sel;
    logic [1:0] resp, hyp, hyn;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int code; // bench model value of a register
    // small package so reserved codes are exercised
    cmpms_top #(.SMALL_PACKAGE(1'b1)) dut (
        .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cmp_raw(cmp_raw),
        .comparator_enable(cmp_en), .response_mode(resp), .hyst_pos(hyp), .hyst_neg(hyn),
        .positive_pin_sel(pos_sel), .positive_regulator_sel(pos_reg),
        .negative_pin_sel(neg_sel), .negative_regulator_sel(neg_reg),
        .cmp_out_routed(routed), .cmp_irq(cmp_irq));
    cmpms_cmp_model model (.clk_sys(clk_sys), .power(cmp_en), .response_mode(resp),
        .want(want), .cmp_raw(cmp_raw));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // hang guard, the run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask : wr
    // read strobe, data compared once settled
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        @(negedge clk_sys);
        chk(sfr_rdata, exp);
    endtask : rdc
    // bounded wait for the request level, looked at on falling edges where it is settled
    task automatic wait_irq(input logic lvl);
        @(negedge clk_sys);
        for (int n = 0; n < 40 && cmp_irq !== lvl; n++) begin
            @(negedge clk_sys);
        end
    endtask : wait_irq
    // reserved codes six and seven give no pin here
    function automatic logic [7:0] pin_exp(int c);
        return (c < 6) ? 8'(1 << c) : 8'h00;
    endfunction : pin_exp
    task automatic end_sim();
        $display("errors=%0d checks=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        code = $urandom(22);
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(CMPMS_ADDR_CONTROL, 8'h00);
        rdc(CMPMS_ADDR_MODE, 8'h02);
        rdc(CMPMS_ADDR_INSEL, 8'hFF);
        rdc(8'h9E, 8'h00);
        chk({6'h00, resp}, 8'h02);
        // random mode values, every response code, spare bits dropped
        for (int i = 0; i < 8; i++) begin
            code = ($urandom & 'hFC) | (i % 4);
            wr(CMPMS_ADDR_MODE, 8'(code));
            rdc(CMPMS_ADDR_MODE, 8'(code & 'h33));
            chk({6'h00, resp}, 8'(i % 4));
        end
        // every select code on both inputs; chosen pins taken as analog
        for (int c = 0; c < 16; c++) begin
            wr(CMPMS_ADDR_INSEL, 8'((15 - c) * 16 + c));
            rdc(CMPMS_ADDR_INSEL, 8'((15 - c) * 16 + c));
            chk(pos_sel, pin_exp(c));
            chk(neg_sel, pin_exp(15 - c));
            chk({6'h00, pos_reg, neg_reg}, {6'h00, c == 8, c == 7});
        end
        // power up, let false edges pass, then clear both flags
        wr(CMPMS_ADDR_MODE, 8'h30);
        wr(CMPMS_ADDR_CONTROL, 8'h89);
        repeat (12) @(posedge clk_sys);
        wr(CMPMS_ADDR_CONTROL, 8'h89);
        wait_irq(1'b0);
        chk({4'h0, hyp, hyn}, 8'h09);
        @(posedge clk_sys);
        want <= 1'b1;
        wait_irq(1'b1);
        chk({7'h00, cmp_irq}, 8'h01);
        chk({7'h00, routed}, 8'h01);
        rdc(CMPMS_ADDR_CONTROL, 8'hE9);
        // rise masked, fall allowed, slowest response
        wr(CMPMS_ADDR_MODE, 8'h13);
        wait_irq(1'b0);
        chk({7'h00, cmp_irq}, 8'h00);
        @(posedge clk_sys);
        want <= 1'b0;
        wait_irq(1'b1);
        chk({7'h00, cmp_irq}, 8'h01);
        rdc(CMPMS_ADDR_CONTROL, 8'hB9);
        wr(CMPMS_ADDR_CONTROL, 8'h89);
        wait_irq(1'b0);
        rdc(CMPMS_ADDR_CONTROL, 8'h89);
        // switched off while the raw line wanders
        wr(CMPMS_ADDR_CONTROL, 8'h00);
        repeat (4) @(posedge clk_sys);
        for (int n = 0; n < 8; n++) begin
            @(negedge clk_sys);
            chk({6'h00, cmp_en, routed}, 8'h00);
        end
        end_sim();
    end
endmodule : cmpms_top_tb
